// ==== contact_switch_model.sv ====
// Switch panel model driving the four contact inputs
`default_nettype none
module contact_switch_model (
  // Clock
  input  wire logic       sys_clk,
  // Requested switch states and their pin positions
  input  wire logic       dir_on,
  input  wire logic       first_on,
  input  wire logic       second_on,
  input  wire logic [1:0] pos_dir,
  input  wire logic [1:0] pos_first,
  input  wire logic [1:0] pos_second,
  // Contact pins
  output logic      [3:0] contact_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] next_contact_in;
  // Unwired pins sit at the pull-down level, never the last value
  always_comb begin
    next_contact_in = 4'h0;
    next_contact_in[pos_dir] = dir_on;
    next_contact_in[pos_first] = first_on;
    next_contact_in[pos_second] = second_on;
  end
  always_ff @(posedge sys_clk) begin
    contact_in <= next_contact_in;
  end
endmodule
`default_nettype wire

// ==== internal_speed_select.sv ====
// Internal set speed selector with APB parameter registers
// Operation
// - Control method field value 3 enables internal speed mode, latched at restart.
// - Motor type picks rotary set (rpm) or linear set (mm/s).
// - Rotary speeds accept 0..10000, defaults 100/200/300, effective immediately.
// - Linear speeds accept 0..10000, defaults 10/20/30, effective immediately.
// - Direct drive motor makes rotary setting unit a tenth of rpm.
// - Selected speed above motor maximum is clamped to that maximum.
// - Allocation field 0 reads inputs from fixed default positions.
// - Allocation field 1 reads inputs from user-assigned positions.
// - Direction input chooses travel direction of the selected speed.
// - Two selection inputs decode to one stored speed or none.
// - Speed reference comes only from stored settings, no external reference.
// - Off/off stop, off/on one, on/on two, on/off three; direction on reverses.
//
// The address map and the APB slave port were left to the implementer.
`include "speed_select_consts.svh"
`default_nettype none

module internal_speed_select (
  // Clock, reset, enable
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Contact inputs, four input positions, active high = on
  input  wire logic [3:0]                    contact_in,
  // Speed reference
  output logic                               mode_active,
  output logic                               motor_reverse,
  output logic      [19:0]                   speed_command,
  output speed_select_pkg::speed_choice_type speed_choice
);
  import speed_select_pkg::*;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] basic_function_setting;
  logic        input_allocation_setting;
  logic [15:0] rotary_speed_one;
  logic [15:0] rotary_speed_two;
  logic [15:0] rotary_speed_three;
  logic [15:0] linear_speed_one;
  logic [15:0] linear_speed_two;
  logic [15:0] linear_speed_three;
  logic [1:0]  motor_config;
  logic [19:0] max_speed;
  logic [11:0] pin_assign;
  logic        restart_seen;
  logic [15:0] next_basic_function_setting;
  logic        next_input_allocation_setting;
  logic [15:0] next_rotary_speed_one;
  logic [15:0] next_rotary_speed_two;
  logic [15:0] next_rotary_speed_three;
  logic [15:0] next_linear_speed_one;
  logic [15:0] next_linear_speed_two;
  logic [15:0] next_linear_speed_three;
  logic [1:0]  next_motor_config;
  logic [19:0] next_max_speed;
  logic [11:0] next_pin_assign;
  logic        next_restart_seen;
  logic        next_mode_active;
  logic [31:0] next_prdata;

  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [15:0] wr_speed;
  logic        restart_cmd;
  logic [3:0]  method_field;

  // ****************************************************************
  // APB handshake and address decode
  // ****************************************************************
  // Zero wait states: every register answers in its access phase
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;
  // Restart command reloads the method but keeps every stored setting
  assign restart_cmd = wr_en && (paddr == `OFS_STATUS) && pwdata[`RESTART_CMD_BIT];

  always_comb begin
    case (paddr)
      `OFS_BASIC_FUNCTION, `OFS_INPUT_ALLOC, `OFS_ROTARY_ONE, `OFS_ROTARY_TWO,
      `OFS_ROTARY_THREE, `OFS_LINEAR_ONE, `OFS_LINEAR_TWO, `OFS_LINEAR_THREE,
      `OFS_MOTOR_CONFIG, `OFS_MAX_SPEED, `OFS_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ****************************************************************
  // Parameter writes
  // ****************************************************************
  // Out-of-range speed writes saturate at the top of the range
  assign wr_speed = (pwdata[31:16] != 16'h0000 || pwdata[15:0] > `SPEED_LIMIT_SETTING) ?
                    `SPEED_LIMIT_SETTING : pwdata[15:0];

  always_comb begin
    next_basic_function_setting   = basic_function_setting;
    next_input_allocation_setting = input_allocation_setting;
    next_rotary_speed_one         = rotary_speed_one;
    next_rotary_speed_two         = rotary_speed_two;
    next_rotary_speed_three       = rotary_speed_three;
    next_linear_speed_one         = linear_speed_one;
    next_linear_speed_two         = linear_speed_two;
    next_linear_speed_three       = linear_speed_three;
    next_motor_config             = motor_config;
    next_max_speed                = max_speed;
    next_pin_assign               = pin_assign;
    if (wr_en) begin
      case (paddr)
        `OFS_BASIC_FUNCTION: next_basic_function_setting = pwdata[15:0];
        `OFS_INPUT_ALLOC: begin
          next_input_allocation_setting = pwdata[`ALLOC_FIELD_BIT];
          next_pin_assign               = pwdata[27:16];
        end
        `OFS_ROTARY_ONE:     next_rotary_speed_one   = wr_speed;
        `OFS_ROTARY_TWO:     next_rotary_speed_two   = wr_speed;
        `OFS_ROTARY_THREE:   next_rotary_speed_three = wr_speed;
        `OFS_LINEAR_ONE:     next_linear_speed_one   = wr_speed;
        `OFS_LINEAR_TWO:     next_linear_speed_two   = wr_speed;
        `OFS_LINEAR_THREE:   next_linear_speed_three = wr_speed;
        `OFS_MOTOR_CONFIG:   next_motor_config       = pwdata[1:0];
        `OFS_MAX_SPEED:      next_max_speed          = pwdata[19:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Restart latch of the control method
  // ****************************************************************
  assign method_field = basic_function_setting[`CTRL_METHOD_MSB:`CTRL_METHOD_LSB];

  // Method is taken at reset release or on a restart command only;
  // a plain write waits, so the drive never changes mode mid-move
  always_comb begin
    next_restart_seen = 1'b1;
    next_mode_active  = mode_active;
    if (!restart_seen || restart_cmd) begin
      next_mode_active = (method_field == `CTRL_METHOD_INTERNAL);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      restart_seen <= 1'b0;
      mode_active  <= 1'b0;
    end else if (clk_en) begin
      restart_seen <= next_restart_seen;
      mode_active  <= next_mode_active;
    end
  end

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  logic [3:0] contact_meta;
  logic [3:0] contact_sync;
  logic [3:0] next_contact_meta;
  logic [3:0] next_contact_sync;
  logic       speed_over_max;
  logic [1:0] dir_pos;
  logic [1:0] first_pos;
  logic [1:0] second_pos;
  logic       dir_on;
  logic       first_on;
  logic       second_on;
  speed_choice_type choice;
  logic [15:0] raw_setting;
  logic [19:0] scaled_setting;
  logic [19:0] next_speed_command;
  logic        next_motor_reverse;
  speed_choice_type next_speed_choice;

  // Contacts are asynchronous to sys_clk: two stages before any decode
  always_comb begin
    next_contact_meta = contact_in;
    next_contact_sync = contact_meta;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      contact_meta <= 4'h0;
      contact_sync <= 4'h0;
    end else if (clk_en) begin
      contact_meta <= next_contact_meta;
      contact_sync <= next_contact_sync;
    end
  end

  // ****************************************************************
  // Input position select and decode
  // ****************************************************************

  always_comb begin
    if (input_allocation_setting) begin
      dir_pos    = pin_assign[`ASSIGN_DIR_LSB+:2];
      first_pos  = pin_assign[`ASSIGN_FIRST_LSB+:2];
      second_pos = pin_assign[`ASSIGN_SECOND_LSB+:2];
    end else begin
      dir_pos    = `DEFAULT_DIR_POS;
      first_pos  = `DEFAULT_FIRST_POS;
      second_pos = `DEFAULT_SECOND_POS;
    end
  end

  assign dir_on    = contact_sync[dir_pos];
  assign first_on  = contact_sync[first_pos];
  assign second_on = contact_sync[second_pos];

  always_comb begin
    case ({first_on, second_on})
      2'b01:   choice = SEL_SPEED_ONE;
      2'b11:   choice = SEL_SPEED_TWO;
      2'b10:   choice = SEL_SPEED_THREE;
      default: choice = SEL_STOP;
    endcase
  end

  always_comb begin
    raw_setting = 16'h0000;
    case (choice)
      SEL_SPEED_ONE:   raw_setting = motor_config[`MOTOR_LINEAR_BIT] ?
                                     linear_speed_one : rotary_speed_one;
      SEL_SPEED_TWO:   raw_setting = motor_config[`MOTOR_LINEAR_BIT] ?
                                     linear_speed_two : rotary_speed_two;
      SEL_SPEED_THREE: raw_setting = motor_config[`MOTOR_LINEAR_BIT] ?
                                     linear_speed_three : rotary_speed_three;
      default:         raw_setting = 16'h0000;
    endcase
  end

  // ****************************************************************
  // Speed reference
  // ****************************************************************
  // Output unit is 0.1 rpm or 0.1 mm/s; direct drive rotary settings already are
  assign scaled_setting = (motor_config[`MOTOR_DIRECT_BIT] && !motor_config[`MOTOR_LINEAR_BIT]) ?
                          {4'h0, raw_setting} :
                          20'({4'h0, raw_setting} * 20'h0000a);

  // Over-range settings are clamped, never refused
  assign speed_over_max = scaled_setting > max_speed;

  always_comb begin
    next_speed_command = 20'h00000;
    next_motor_reverse = 1'b0;
    next_speed_choice  = SEL_STOP;
    // Reference is built only from stored settings
    if (mode_active) begin
      next_speed_command = speed_over_max ? max_speed : scaled_setting;
      next_motor_reverse = dir_on;
      next_speed_choice  = choice;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_command <= 20'h00000;
      motor_reverse <= 1'b0;
      speed_choice  <= SEL_STOP;
    end else if (clk_en) begin
      speed_command <= next_speed_command;
      motor_reverse <= next_motor_reverse;
      speed_choice  <= next_speed_choice;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Loaded in the setup cycle, so the word stands through the access phase
  always_comb begin
    next_prdata = prdata;
    if (rd_en) begin
      case (paddr)
        `OFS_BASIC_FUNCTION: next_prdata = {16'h0000, basic_function_setting};
        `OFS_INPUT_ALLOC:    next_prdata = {4'h0, pin_assign, 15'h0000, input_allocation_setting};
        `OFS_ROTARY_ONE:     next_prdata = {16'h0000, rotary_speed_one};
        `OFS_ROTARY_TWO:     next_prdata = {16'h0000, rotary_speed_two};
        `OFS_ROTARY_THREE:   next_prdata = {16'h0000, rotary_speed_three};
        `OFS_LINEAR_ONE:     next_prdata = {16'h0000, linear_speed_one};
        `OFS_LINEAR_TWO:     next_prdata = {16'h0000, linear_speed_two};
        `OFS_LINEAR_THREE:   next_prdata = {16'h0000, linear_speed_three};
        `OFS_MOTOR_CONFIG:   next_prdata = {30'h00000000, motor_config};
        `OFS_MAX_SPEED:      next_prdata = {12'h000, max_speed};
        `OFS_STATUS:         next_prdata = {8'h00, speed_command, motor_reverse,
                                            speed_choice, mode_active};
        default:             next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      prdata <= next_prdata;
    end
  end

  // ****************************************************************
  // Parameter registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      basic_function_setting   <= `RST_BASIC_FUNCTION;
      input_allocation_setting <= 1'b0;
      rotary_speed_one         <= `RST_ROTARY_ONE;
      rotary_speed_two         <= `RST_ROTARY_TWO;
      rotary_speed_three       <= `RST_ROTARY_THREE;
      linear_speed_one         <= `RST_LINEAR_ONE;
      linear_speed_two         <= `RST_LINEAR_TWO;
      linear_speed_three       <= `RST_LINEAR_THREE;
      motor_config             <= 2'h0;
      max_speed                <= `RST_MAX_SPEED;
      pin_assign               <= `RST_PIN_ASSIGN;
    end else if (clk_en) begin
      basic_function_setting   <= next_basic_function_setting;
      input_allocation_setting <= next_input_allocation_setting;
      rotary_speed_one         <= next_rotary_speed_one;
      rotary_speed_two         <= next_rotary_speed_two;
      rotary_speed_three       <= next_rotary_speed_three;
      linear_speed_one         <= next_linear_speed_one;
      linear_speed_two         <= next_linear_speed_two;
      linear_speed_three       <= next_linear_speed_three;
      motor_config             <= next_motor_config;
      max_speed                <= next_max_speed;
      pin_assign               <= next_pin_assign;
    end
  end

endmodule
`default_nettype wire

// ==== internal_speed_select_monitor.sv ====
// Port checker for the internal set speed selector
`default_nettype none
module internal_speed_select_monitor (
  // Clock and reset
  input wire logic             sys_clk,
  input wire logic             rst_n,
  input wire logic             clk_en,
  // APB
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // Contacts and reference
  input wire logic [3:0]       contact_in,
  input wire logic             mode_active,
  input wire logic             motor_reverse,
  input wire logic [19:0]      speed_command,
  input wire speed_select_pkg::speed_choice_type speed_choice
);
  timeunit 1ns;
  timeprecision 1ps;
  import speed_select_pkg::*;
  logic [3:0] rst_age;
  logic [3:0] next_rst_age;
  // Saturating age since reset, so startup loads are not judged
  always_comb begin
    next_rst_age = (rst_age == 4'hf) ? rst_age : rst_age + 4'h1;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rst_age <= 4'h0;
    else rst_age <= next_rst_age;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence quiet_inputs;
    (rst_age == 4'hf && clk_en && !psel && $stable(contact_in))[*8];
  endsequence
  chk_stop_zero: assert property (
    speed_choice == SEL_STOP |-> speed_command == 20'h0) else $error("speed not zero at stop");
  chk_inactive_quiet: assert property (
    !mode_active |-> speed_command == 20'h0 && !motor_reverse) else $error("output while inactive");
  chk_choice_mode: assert property (
    speed_choice != SEL_STOP |-> mode_active) else $error("speed chosen while inactive");
  chk_speed_ceiling: assert property (
    speed_command <= 20'h186a0) else $error("speed above ceiling");
  chk_mode_restart: assert property (
    rst_age == 4'hf && !$past(psel && penable && pwrite && paddr == 12'h028 && pwdata[0]) |->
    $stable(mode_active)) else $error("mode changed without restart");
  chk_sync_hold: assert property (
    quiet_inputs |-> $stable(speed_choice) && $stable(motor_reverse)) else $error("output moved");
  chk_bad_addr: assert property (
    psel && penable && paddr == 12'h030 |-> pslverr) else $error("unmapped access accepted");
  chk_zero_wait: assert property (
    psel && penable |-> pready) else $error("access phase stalled");
endmodule
bind internal_speed_select internal_speed_select_monitor mon (
  .sys_clk, .rst_n, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .contact_in, .mode_active, .motor_reverse, .speed_command, .speed_choice);
`default_nettype wire

// ==== internal_speed_select_tb_top.sv ====
// Testbench for the internal set speed selector
`include "speed_select_consts.svh"
`default_nettype none
module internal_speed_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import speed_select_pkg::*;
  logic sys_clk, rst_n, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic mode_active, motor_reverse, dir_on, first_on, second_on;
  logic [1:0] pos_dir, pos_first, pos_second;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] contact_in;
  logic [19:0] speed_command;
  speed_choice_type speed_choice;
  int n_mismatch, cmp_count, cycles;
  typedef struct packed {
    logic d; logic a; logic b; logic [1:0] cfg; speed_choice_type ch; logic [19:0] spd;
  } row_type;
  localparam row_type ROWS [11] = '{
    '{1'b0, 1'b0, 1'b0, 2'h0, SEL_STOP, 20'h0}, '{1'b0, 1'b0, 1'b1, 2'h0, SEL_SPEED_ONE, 20'h3e8},
    '{1'b0, 1'b1, 1'b1, 2'h0, SEL_SPEED_TWO, 20'h7d0},
    '{1'b0, 1'b1, 1'b0, 2'h0, SEL_SPEED_THREE, 20'hbb8},
    '{1'b1, 1'b0, 1'b0, 2'h0, SEL_STOP, 20'h0}, '{1'b1, 1'b0, 1'b1, 2'h0, SEL_SPEED_ONE, 20'h3e8},
    '{1'b0, 1'b0, 1'b1, 2'h1, SEL_SPEED_ONE, 20'h64}, '{1'b1, 1'b1, 1'b1, 2'h1, SEL_SPEED_TWO, 20'hc8},
    '{1'b0, 1'b1, 1'b0, 2'h1, SEL_SPEED_THREE, 20'h12c},
    '{1'b0, 1'b0, 1'b1, 2'h2, SEL_SPEED_ONE, 20'h64},
    '{1'b1, 1'b1, 1'b0, 2'h2, SEL_SPEED_THREE, 20'h12c}};
  localparam logic [11:0] RADDR [9] = '{`OFS_BASIC_FUNCTION, `OFS_INPUT_ALLOC, `OFS_ROTARY_ONE,
    `OFS_ROTARY_TWO, `OFS_ROTARY_THREE, `OFS_LINEAR_ONE, `OFS_LINEAR_TWO, `OFS_LINEAR_THREE,
    `OFS_MAX_SPEED};
  localparam logic [31:0] RVAL [9] = '{32'h0, 32'h02100000, 32'h64, 32'hc8, 32'h12c, 32'ha,
    32'h14, 32'h1e, 32'h186a0};
  internal_speed_select dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .contact_in(contact_in), .mode_active(mode_active),
    .motor_reverse(motor_reverse), .speed_command(speed_command), .speed_choice(speed_choice));
  contact_switch_model sw (.sys_clk(sys_clk), .dir_on(dir_on), .first_on(first_on),
    .second_on(second_on), .pos_dir(pos_dir), .pos_first(pos_first), .pos_second(pos_second),
    .contact_in(contact_in));
  always #5 sys_clk = ~sys_clk;
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic drive(input logic d, input logic a, input logic b);
    @(posedge sys_clk);
    dir_on <= d; first_on <= a; second_on <= b;
    repeat (10) @(posedge sys_clk);
  endtask
  initial begin
    sys_clk = 0; rst_n = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; dir_on = 0; first_on = 0; second_on = 0; cycles = 0;
    pos_dir = `DEFAULT_DIR_POS; pos_first = `DEFAULT_FIRST_POS; pos_second = `DEFAULT_SECOND_POS;
    repeat (20) @(posedge sys_clk);
    check("reset speed", {12'h0, speed_command}, 32'h0);
    check("reset pready", {31'h0, pready}, 32'h1);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, RADDR[i], 32'h0);
      check("reset value", rd, RVAL[i]);
    end
    apb(1'b0, 12'h030, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("test reset values done");
    apb(1'b1, `OFS_BASIC_FUNCTION, 32'h30);
    repeat (4) @(posedge sys_clk);
    check("mode before restart", {31'h0, mode_active}, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("mode after reset", {31'h0, mode_active}, 32'h0);
    apb(1'b0, `OFS_BASIC_FUNCTION, 32'h0);
    check("method after reset", rd, 32'h0);
    apb(1'b1, `OFS_BASIC_FUNCTION, 32'h30);
    apb(1'b1, `OFS_STATUS, 32'h1 << `RESTART_CMD_BIT);
    repeat (2) @(posedge sys_clk);
    check("mode after restart", {31'h0, mode_active}, 32'h1);
    $display("test restart done");
    foreach (ROWS[i]) begin
      apb(1'b1, `OFS_MOTOR_CONFIG, {30'h0, ROWS[i].cfg});
      drive(ROWS[i].d, ROWS[i].a, ROWS[i].b);
      check("choice", {30'h0, speed_choice}, {30'h0, ROWS[i].ch});
      check("speed", {12'h0, speed_command}, {12'h0, ROWS[i].spd});
      check("reverse", {31'h0, motor_reverse}, {31'h0, ROWS[i].d});
    end
    $display("test decode table done");
    apb(1'b1, `OFS_MOTOR_CONFIG, 32'h0);
    drive(1'b0, 1'b1, 1'b1);
    apb(1'b1, `OFS_ROTARY_TWO, 32'h1f4);
    repeat (2) @(posedge sys_clk);
    check("live setting", {12'h0, speed_command}, 32'h1388);
    apb(1'b1, `OFS_MAX_SPEED, 32'h5dc);
    drive(1'b0, 1'b1, 1'b0);
    check("clamped speed", {12'h0, speed_command}, 32'h5dc);
    apb(1'b1, `OFS_MAX_SPEED, 32'h186a0);
    apb(1'b1, `OFS_ROTARY_ONE, 32'h4e20);
    apb(1'b0, `OFS_ROTARY_ONE, 32'h0);
    check("saturated setting", rd, 32'h2710);
    drive(1'b0, 1'b0, 1'b1);
    check("top speed", {12'h0, speed_command}, 32'h186a0);
    $display("test limits done");
    apb(1'b1, `OFS_INPUT_ALLOC, 32'h01030001);
    @(posedge sys_clk);
    pos_dir <= 2'h3; pos_first <= 2'h0; pos_second <= 2'h1;
    drive(1'b1, 1'b1, 1'b0);
    check("assigned choice", {30'h0, speed_choice}, {30'h0, SEL_SPEED_THREE});
    check("assigned reverse", {31'h0, motor_reverse}, 32'h1);
    $display("test user allocation done");
    apb(1'b0, `OFS_STATUS, 32'h0);
    check("status word", rd, 32'h0000bb8f);
    clk_en <= 1'b0;
    drive(1'b0, 1'b0, 1'b1);
    check("frozen choice", {30'h0, speed_choice}, {30'h0, SEL_SPEED_THREE});
    clk_en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check("resumed choice", {30'h0, speed_choice}, {30'h0, SEL_SPEED_ONE});
    $display("test status and enable done");
    test_done();
  end
endmodule
`default_nettype wire

// ==== speed_select_consts.svh ====
// Constants for the internal set speed selector
`ifndef SPEED_SELECT_CONSTS_SVH
`define SPEED_SELECT_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define OFS_BASIC_FUNCTION    12'h000
`define OFS_INPUT_ALLOC       12'h004
`define OFS_ROTARY_ONE        12'h008
`define OFS_ROTARY_TWO        12'h00c
`define OFS_ROTARY_THREE      12'h010
`define OFS_LINEAR_ONE        12'h014
`define OFS_LINEAR_TWO        12'h018
`define OFS_LINEAR_THREE      12'h01c
`define OFS_MOTOR_CONFIG      12'h020
`define OFS_MAX_SPEED         12'h024
`define OFS_STATUS            12'h028

// ****************************************************************
// Fields and values
// ****************************************************************
`define CTRL_METHOD_LSB       4
`define CTRL_METHOD_MSB       7
`define CTRL_METHOD_INTERNAL  4'h3
`define ALLOC_FIELD_BIT       0
`define MOTOR_LINEAR_BIT      0
`define MOTOR_DIRECT_BIT      1
`define RESTART_CMD_BIT       0
`define ASSIGN_DIR_LSB        0
`define ASSIGN_FIRST_LSB      4
`define ASSIGN_SECOND_LSB     8
`define SPEED_LIMIT_SETTING   16'h2710
`define RST_BASIC_FUNCTION    16'h0000
`define RST_ROTARY_ONE        16'h0064
`define RST_ROTARY_TWO        16'h00c8
`define RST_ROTARY_THREE      16'h012c
`define RST_LINEAR_ONE        16'h000a
`define RST_LINEAR_TWO        16'h0014
`define RST_LINEAR_THREE      16'h001e
`define RST_MAX_SPEED         20'h186a0
`define RST_PIN_ASSIGN        12'h210
`define DEFAULT_DIR_POS       2'h0
`define DEFAULT_FIRST_POS     2'h1
`define DEFAULT_SECOND_POS    2'h2

`endif

// ==== speed_select_pkg.sv ====
// Types for the internal set speed selector
`default_nettype none
package speed_select_pkg;
  typedef enum logic [1:0] {
    SEL_STOP,
    SEL_SPEED_ONE,
    SEL_SPEED_TWO,
    SEL_SPEED_THREE
  } speed_choice_type;
endpackage
`default_nettype wire
